// file: hw/sip_servo_ctrl.sv
// Internal position table, overload protection and servo enable logic with Avalon-MM registers
// Functional notes
// - Battery check enabled: fault raises alarm; disabled: no check, no alarm.
// - Integrate torque squared over detect point; both thresholds 10 to 300 percent.
// - Overload integration bounded by a maximum time of 0 to 1000 s.
// - Configured 0 to 100 percent current is applied during encoder reset.
// - Torque-reached output asserts at configured 0 to 300 percent threshold.
// - Force bit 0: enable follows input; 1: enable without external signal.
// - Target equals turns times 131072 plus pulses times 4, both signed 16-bit.
// - Four target entries 0 to 3, each with turns and pulses.
// - Each entry moves at its own speed, 0 to 6000 r/min.
// - One shared acceleration setting 0 to 2000; larger is faster.
// - Input port 0 is fixed to servo enable.
// - Pole-pair count 1 to 36 feeds commutation and speed math.
// - Configurable inputs: function code 1 is servo enable, 0 is none.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module sip_servo_ctrl #(
  parameter int NUM_IN = 5,
  parameter int TICK_CYC = sip_pkg::SIP_TICK_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Pins from the outside
  input wire logic [NUM_IN-1:0] i_in_port,
  input wire logic i_batt_fault,
  // Drive-internal signals on this clock
  input wire logic [8:0] i_torque_pct,
  input wire logic i_enc_resetting,
  input wire logic i_move_done,
  // Status and control outputs
  output logic o_servo_en,
  output logic o_batt_alarm,
  output logic o_therm_alarm,
  output logic o_torque_reached,
  output logic [6:0] o_enc_current,
  // Motion settings to the position loop
  output logic o_move_busy,
  output logic signed [sip_pkg::SIP_POS_W-1:0] o_target_pos,
  output logic [15:0] o_target_speed,
  output logic [15:0] o_accel,
  output logic [5:0] o_pole_pairs,
  output logic [15:0] o_gain_atten,
  // Interrupt
  output logic o_irq
);
  import sip_pkg::*;
  // Elaboration checks on port count and tick length
  if (NUM_IN < 2 || NUM_IN > 7) $error("NUM_IN must be 2 to 7");
  if (TICK_CYC < 1) $error("TICK_CYC must be at least 1");
  function automatic logic in_rng(input logic [31:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (v[31:16] == 16'h0000) && (v[15:0] >= lo) && (v[15:0] <= hi);
  endfunction : in_rng
  // Bus request decode
  logic wait_reg;
  wire req = i_avs_read | i_avs_write;
  wire acc_edge = req & ~wait_reg;
  wire wr = i_avs_write & acc_edge;
  wire [31:0] wd = i_avs_writedata;
  wire ent_hit = (i_avs_address[7:6] == SIP_ENTRY_PAGE);
  wire [1:0] ent_idx = i_avs_address[5:4];
  wire [1:0] ent_fld = i_avs_address[3:2];
  wire wr_ctrl = wr && i_avs_address == SIP_CTRL_OFS;
  // Configuration registers
  logic [1:0] ctrl_reg;
  logic [15:0] thdet_reg, thtrq_reg, thtime_reg, enccur_reg, trqrch_reg;
  logic [15:0] poles_reg, atten_reg, accel_reg;
  logic [4*(NUM_IN-1)-1:0] infunc_reg;
  logic [SIP_IRQ_W-1:0] istat_reg, imask_reg;
  sip_entry_type entry_reg [4];
  // Out-of-range writes are dropped so the loop never sees an illegal setting
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg <= SIP_CTRL_RST;
      thdet_reg <= SIP_TH_RST;
      thtrq_reg <= SIP_THTRQ_RST;
      thtime_reg <= SIP_ONE_RST;
      enccur_reg <= '0;
      trqrch_reg <= SIP_TH_RST;
      poles_reg <= SIP_ONE_RST;
      atten_reg <= SIP_ONE_RST;
      accel_reg <= '0;
      infunc_reg <= '0;
      imask_reg <= '0;
      for (int i = 0; i < 4; i++) entry_reg[i] <= '0;
    end else if (wr) begin
      case (i_avs_address)
        SIP_CTRL_OFS: ctrl_reg <= wd[1:0];
        SIP_THDET_OFS: if (in_rng(wd, SIP_TH_MIN, SIP_TH_MAX)) thdet_reg <= wd[15:0];
        SIP_THTRQ_OFS: if (in_rng(wd, SIP_TH_MIN, SIP_TH_MAX)) thtrq_reg <= wd[15:0];
        SIP_THTIME_OFS: if (in_rng(wd, '0, SIP_THTIME_MAX)) thtime_reg <= wd[15:0];
        SIP_ENCCUR_OFS: if (in_rng(wd, '0, SIP_ENCCUR_MAX)) enccur_reg <= wd[15:0];
        SIP_TRQRCH_OFS: if (in_rng(wd, '0, SIP_TRQRCH_MAX)) trqrch_reg <= wd[15:0];
        SIP_POLES_OFS: if (in_rng(wd, SIP_POLES_MIN, SIP_POLES_MAX)) poles_reg <= wd[15:0];
        SIP_ATTEN_OFS: if (in_rng(wd, SIP_ATTEN_MIN, SIP_ATTEN_MAX)) atten_reg <= wd[15:0];
        SIP_ACCEL_OFS: if (in_rng(wd, '0, SIP_ACCEL_MAX)) accel_reg <= wd[15:0];
        SIP_INFUNC_OFS: infunc_reg <= wd[4*(NUM_IN-1)-1:0];
        SIP_IMASK_OFS: imask_reg <= wd[SIP_IRQ_W-1:0];
        default: begin
          if (ent_hit && ent_fld == SIP_FLD_TURNS) entry_reg[ent_idx].turns <= wd[15:0];
          if (ent_hit && ent_fld == SIP_FLD_PULSES) entry_reg[ent_idx].pulses <= wd[15:0];
          if (ent_hit && ent_fld == SIP_FLD_SPEED && in_rng(wd, '0, SIP_SPEED_MAX))
            entry_reg[ent_idx].speed <= wd[15:0];
        end
      endcase
    end
  end
  // Pin synchronisers: the first stage feeds only the second
  logic [NUM_IN:0] pin_s1_reg, pin_s2_reg;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {pin_s2_reg, pin_s1_reg} <= '0;
    end else begin
      {pin_s2_reg, pin_s1_reg} <= {pin_s1_reg, i_batt_fault, i_in_port};
    end
  end
  wire [NUM_IN-1:0] in_s = pin_s2_reg[NUM_IN-1:0];
  wire batt_s = pin_s2_reg[NUM_IN];
  // Function decode: field 0..7 gives code 0..7, field 8..15 gives code 16..23
  // Codes 8 to 15 are traded away so that entry select and start fit in four bits
  wire [NUM_IN-1:0] hit_en, hit_s0, hit_s1, hit_go;
  assign hit_en[0] = in_s[0];
  assign {hit_go[0], hit_s1[0], hit_s0[0]} = 3'b000;
  for (genvar p = 1; p < NUM_IN; p++) begin : g_fn
    wire [4:0] code = {infunc_reg[4*p-1], 1'b0, infunc_reg[4*p-2 -: 3]};
    assign hit_en[p] = in_s[p] && code == SIP_FN_SRVEN;
    assign hit_s0[p] = in_s[p] && code == SIP_FN_SEL0;
    assign hit_s1[p] = in_s[p] && code == SIP_FN_SEL1;
    assign hit_go[p] = in_s[p] && code == SIP_FN_START;
  end
  wire ext_en = |hit_en;
  wire [1:0] sel = {|hit_s1, |hit_s0};
  wire go = |hit_go;

  // Target formation per entry, sign-extended then scaled
  wire signed [SIP_POS_W-1:0] sel_target =
    ($signed({{(SIP_POS_W-16){entry_reg[sel].turns[15]}}, entry_reg[sel].turns})
      <<< SIP_TURN_SHIFT) +
    ($signed({{(SIP_POS_W-16){entry_reg[sel].pulses[15]}}, entry_reg[sel].pulses})
      <<< SIP_PULSE_SHIFT);

  // Move sequencer: start edge latches one entry, later selection ignored
  sip_move_type move_reg, move_next;
  logic go_d_reg;
  wire go_rise = go & ~go_d_reg;
  always_comb begin
    case (move_reg)
      SIP_IDLE: move_next = go_rise ? SIP_BUSY : SIP_IDLE;
      SIP_BUSY: move_next = i_move_done ? SIP_IDLE : SIP_BUSY;
      default: move_next = SIP_IDLE;
    endcase
  end
  wire latch = (move_reg == SIP_IDLE) & go_rise;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      move_reg <= SIP_IDLE;
      go_d_reg <= 1'b0;
      o_move_busy <= 1'b0;
      o_target_pos <= '0;
      o_target_speed <= '0;
    end else begin
      move_reg <= move_next;
      go_d_reg <= go;
      o_move_busy <= (move_next == SIP_BUSY);
      if (latch) begin
        o_target_pos <= sel_target;
        o_target_speed <= entry_reg[sel].speed;
      end
    end
  end
  wire done_ev = (move_reg == SIP_BUSY) & i_move_done;
  // I-squared-t integration on a 1 ms tick; cooling drains the same measure
  logic [$clog2(TICK_CYC+1)-1:0] tick_cnt_reg;
  logic [39:0] thacc_reg;
  wire tick = (tick_cnt_reg == '0);
  wire [17:0] trq_sq = 18'(i_torque_pct) * 18'(i_torque_pct);
  wire [17:0] det_sq = 18'(thdet_reg[8:0]) * 18'(thdet_reg[8:0]);
  wire [17:0] lim_sq = 18'(thtrq_reg[8:0]) * 18'(thtrq_reg[8:0]);
  wire heating = i_torque_pct > thdet_reg[8:0];
  wire [17:0] sq_gain = heating ? trq_sq - det_sq : det_sq - trq_sq;
  wire [17:0] sq_span = (lim_sq > det_sq) ? lim_sq - det_sq : '0;
  // Budget: overload torque held for the full maximum time
  wire [39:0] th_limit = 40'(sq_span) * 40'(thtime_reg) * SIP_TICKS_PER_S;
  wire [39:0] acc_sum = thacc_reg + 40'(sq_gain); // Sum first: a zero budget cannot wrap
  wire [39:0] acc_up = (acc_sum > th_limit) ? th_limit + 40'h1 : acc_sum;
  wire [39:0] acc_dn = (thacc_reg > 40'(sq_gain)) ? thacc_reg - 40'(sq_gain) : '0;
  wire th_trip = thacc_reg > th_limit;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_cnt_reg <= '0;
      thacc_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? ($clog2(TICK_CYC+1))'(TICK_CYC - 1) : tick_cnt_reg - 1'b1;
      if (tick) thacc_reg <= heating ? acc_up : acc_dn;
    end
  end
  // Alarms, enable and analog-style outputs
  wire therm_next = th_trip | (o_therm_alarm & ~(wr_ctrl & wd[SIP_CTRL_THCLR]));
  wire batt_next = ctrl_reg[SIP_CTRL_BATT] & batt_s;
  wire trq_next = {7'h00, i_torque_pct} >= trqrch_reg;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_therm_alarm <= 1'b0;
      o_batt_alarm <= 1'b0;
      o_torque_reached <= 1'b0;
      o_servo_en <= 1'b0;
      o_enc_current <= '0;
    end else begin
      o_therm_alarm <= therm_next;
      o_batt_alarm <= batt_next;
      o_torque_reached <= trq_next;
      o_servo_en <= (ctrl_reg[SIP_CTRL_FORCE] | ext_en) & ~o_therm_alarm;
      o_enc_current <= i_enc_resetting ? enccur_reg[6:0] : '0;
    end
  end
  // Settings mirrored to the loop; attenuation only when not moving
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_accel <= '0;
      o_pole_pairs <= SIP_ONE_RST[5:0];
      o_gain_atten <= SIP_ONE_RST;
    end else begin
      o_accel <= accel_reg;
      o_pole_pairs <= poles_reg[5:0];
      o_gain_atten <= (move_next == SIP_IDLE) ? atten_reg : SIP_ONE_RST;
    end
  end
  // Sticky events, write one to clear; a new event wins over the clear
  logic [SIP_IRQ_W-1:0] ev, ev_d_reg;
  assign ev = {done_ev, o_torque_reached & ~ev_d_reg[SIP_EV_TRQ],
               o_therm_alarm & ~ev_d_reg[SIP_EV_THERM], o_batt_alarm & ~ev_d_reg[SIP_EV_BATT]};
  wire [SIP_IRQ_W-1:0] clr = (wr && i_avs_address == SIP_ISTAT_OFS) ? wd[SIP_IRQ_W-1:0] : '0;
  wire [SIP_IRQ_W-1:0] istat_next = (istat_reg & ~clr) | ev;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      istat_reg <= '0;
      ev_d_reg <= '0;
      o_irq <= 1'b0;
    end else begin
      istat_reg <= istat_next;
      ev_d_reg <= {1'b0, o_torque_reached, o_therm_alarm, o_batt_alarm};
      o_irq <= |(istat_next & imask_reg);
    end
  end
  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (i_avs_address)
      SIP_CTRL_OFS: rd_mux = {30'h0, ctrl_reg};
      SIP_THDET_OFS: rd_mux = {16'h0, thdet_reg};
      SIP_THTRQ_OFS: rd_mux = {16'h0, thtrq_reg};
      SIP_THTIME_OFS: rd_mux = {16'h0, thtime_reg};
      SIP_ENCCUR_OFS: rd_mux = {16'h0, enccur_reg};
      SIP_TRQRCH_OFS: rd_mux = {16'h0, trqrch_reg};
      SIP_POLES_OFS: rd_mux = {16'h0, poles_reg};
      SIP_ATTEN_OFS: rd_mux = {16'h0, atten_reg};
      SIP_ACCEL_OFS: rd_mux = {16'h0, accel_reg};
      SIP_INFUNC_OFS: rd_mux = 32'(infunc_reg);
      SIP_STATUS_OFS: rd_mux = {24'h0, o_servo_en, o_move_busy, sel, o_torque_reached,
                                o_therm_alarm, o_batt_alarm, ext_en};
      SIP_ISTAT_OFS: rd_mux = 32'(istat_reg);
      SIP_IMASK_OFS: rd_mux = 32'(imask_reg);
      SIP_THACC_OFS: rd_mux = thacc_reg[39:8];
      default: begin
        if (ent_hit) begin
          case (ent_fld)
            SIP_FLD_TURNS: rd_mux = {16'h0, entry_reg[ent_idx].turns};
            SIP_FLD_PULSES: rd_mux = {16'h0, entry_reg[ent_idx].pulses};
            SIP_FLD_SPEED: rd_mux = {16'h0, entry_reg[ent_idx].speed};
            default: rd_mux = 32'(o_target_pos);
          endcase
        end
      end
    endcase
  end
  // One wait cycle per access, data ready when waitrequest drops
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wait_reg <= 1'b1;
      o_avs_readdata <= '0;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (req & wait_reg) o_avs_readdata <= rd_mux;
    end
  end
  assign o_avs_waitrequest = wait_reg;
  // Assertions
  sequence s_start;
    (move_reg == SIP_IDLE) && go_rise;
  endsequence
  sequence s_running;
    move_reg == SIP_BUSY;
  endsequence
  a_batt_gate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $rose(o_batt_alarm) |-> $past(ctrl_reg[SIP_CTRL_BATT]))
    else $error("battery alarm raised while check disabled");
  a_wait_once: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    req && wait_reg |=> !wait_reg)
    else $error("waitrequest not released after one cycle");
  a_force_enable: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ctrl_reg[SIP_CTRL_FORCE] && !o_therm_alarm |=> o_servo_en)
    else $error("forced enable did not enable servo");
  a_therm_off: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    th_trip |=> o_therm_alarm ##1 !o_servo_en)
    else $error("overload did not alarm and disable");
  a_trq_reach: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_torque_reached == $past({7'h00, i_torque_pct} >= trqrch_reg))
    else $error("torque reached output wrong");
  a_target_latch: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_start |=> o_target_pos == $past(sel_target) && o_move_busy)
    else $error("target not latched at start");
  a_move_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_running and !i_move_done |=> $stable(o_target_pos) && $stable(o_target_speed))
    else $error("target changed during move");
  a_irq_level: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ##1 o_irq == |($past(istat_next) & $past(imask_reg)))
    else $error("interrupt level mismatch");
  a_limits_held: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    poles_reg >= SIP_POLES_MIN && poles_reg <= SIP_POLES_MAX && accel_reg <= SIP_ACCEL_MAX)
    else $error("setting outside its range");
  a_enc_cur: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !i_enc_resetting |=> o_enc_current == '0)
    else $error("encoder current outside reset");
endmodule : sip_servo_ctrl
`default_nettype wire

// file: include/sip_pkg.sv
// Package: register map, field limits and shared types of the position/protection block
package sip_pkg;
  // Register byte offsets
  localparam logic [7:0] SIP_CTRL_OFS = 8'h00;
  localparam logic [7:0] SIP_THDET_OFS = 8'h04;
  localparam logic [7:0] SIP_THTRQ_OFS = 8'h08;
  localparam logic [7:0] SIP_THTIME_OFS = 8'h0C;
  localparam logic [7:0] SIP_ENCCUR_OFS = 8'h10;
  localparam logic [7:0] SIP_TRQRCH_OFS = 8'h14;
  localparam logic [7:0] SIP_POLES_OFS = 8'h18;
  localparam logic [7:0] SIP_ATTEN_OFS = 8'h1C;
  localparam logic [7:0] SIP_ACCEL_OFS = 8'h20;
  localparam logic [7:0] SIP_INFUNC_OFS = 8'h24;
  localparam logic [7:0] SIP_STATUS_OFS = 8'h28;
  localparam logic [7:0] SIP_ISTAT_OFS = 8'h2C;
  localparam logic [7:0] SIP_IMASK_OFS = 8'h30;
  localparam logic [7:0] SIP_THACC_OFS = 8'h34;
  // Entry window: base 0x40, 16 bytes per entry, field in bits 3:2
  localparam logic [1:0] SIP_ENTRY_PAGE = 2'h1;
  localparam logic [1:0] SIP_FLD_TURNS = 2'h0;
  localparam logic [1:0] SIP_FLD_PULSES = 2'h1;
  localparam logic [1:0] SIP_FLD_SPEED = 2'h2;
  localparam logic [1:0] SIP_FLD_TARGET = 2'h3;
  // Control bits
  localparam int SIP_CTRL_BATT = 0;
  localparam int SIP_CTRL_FORCE = 1;
  localparam int SIP_CTRL_THCLR = 2;
  localparam logic [1:0] SIP_CTRL_RST = 2'h0;
  // Interrupt status bits
  localparam int SIP_IRQ_W = 4;
  localparam int SIP_EV_BATT = 0;
  localparam int SIP_EV_THERM = 1;
  localparam int SIP_EV_TRQ = 2;
  localparam int SIP_EV_DONE = 3;
  // Field limits and reset values
  localparam logic [15:0] SIP_TH_MIN = 16'h000A;
  localparam logic [15:0] SIP_TH_MAX = 16'h012C;
  localparam logic [15:0] SIP_THTIME_MAX = 16'h03E8;
  localparam logic [15:0] SIP_ENCCUR_MAX = 16'h0064;
  localparam logic [15:0] SIP_TRQRCH_MAX = 16'h012C;
  localparam logic [15:0] SIP_POLES_MIN = 16'h0001;
  localparam logic [15:0] SIP_POLES_MAX = 16'h0024;
  localparam logic [15:0] SIP_ATTEN_MIN = 16'h0001;
  localparam logic [15:0] SIP_ATTEN_MAX = 16'h0BB8;
  localparam logic [15:0] SIP_ACCEL_MAX = 16'h07D0;
  localparam logic [15:0] SIP_SPEED_MAX = 16'h1770;
  localparam logic [15:0] SIP_TH_RST = 16'h0064;
  localparam logic [15:0] SIP_THTRQ_RST = 16'h012C;
  localparam logic [15:0] SIP_ONE_RST = 16'h0001;
  // Target position scaling: turns * 131072 + pulses * 4
  localparam int SIP_TURN_SHIFT = 17;
  localparam int SIP_PULSE_SHIFT = 2;
  localparam int SIP_POS_W = 34;
  // Input function codes
  localparam logic [4:0] SIP_FN_NONE = 5'h00;
  localparam logic [4:0] SIP_FN_SRVEN = 5'h01;
  localparam logic [4:0] SIP_FN_SEL0 = 5'h10;
  localparam logic [4:0] SIP_FN_SEL1 = 5'h11;
  localparam logic [4:0] SIP_FN_START = 5'h12;
  // Overload timing: 1 ms integration tick
  localparam int SIP_CLK_NS = 20;
  localparam int SIP_TICK_NS = 1000000;
  localparam int SIP_TICK_CYC = SIP_TICK_NS / SIP_CLK_NS;
  localparam logic [39:0] SIP_TICKS_PER_S = 40'h00_0000_03E8;
  // One internal position entry
  typedef struct packed {
    logic signed [15:0] turns;
    logic signed [15:0] pulses;
    logic [15:0] speed;
  } sip_entry_type;
  // Move sequencer states
  typedef enum logic [1:0] {
    SIP_IDLE = 2'b00,
    SIP_BUSY = 2'b01
  } sip_move_type;
endpackage : sip_pkg

// file: verif/sip_far_model.sv
// Far-side model: motor torque, encoder, battery and discrete pins
`timescale 1ns/1ns
`default_nettype none
module sip_far_model #(
  parameter int DONE_DLY = 3
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Commands from the bench
  input wire logic [8:0] i_torque_cmd,
  input wire logic i_batt_bad,
  input wire logic i_enc_rst_cmd,
  input wire logic [4:0] i_pin_cmd,
  // Move state from the device
  input wire logic i_busy,
  // Toward the device
  output logic [8:0] o_torque_pct,
  output logic o_batt_fault,
  output logic o_enc_resetting,
  output logic [4:0] o_in_port,
  output logic o_move_done
);
  logic [7:0] busy_cnt_reg;
  // Sensors lag the command by one edge, like a real feedback path
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_torque_pct <= 9'h000;
      o_batt_fault <= 1'b0;
      o_enc_resetting <= 1'b0;
      o_in_port <= 5'h00;
      o_move_done <= 1'b0;
      busy_cnt_reg <= 8'h00;
    end else begin
      o_torque_pct <= i_torque_cmd;
      o_batt_fault <= i_batt_bad;
      o_enc_resetting <= i_enc_rst_cmd;
      o_in_port <= i_pin_cmd;
      busy_cnt_reg <= i_busy ? busy_cnt_reg + 8'h01 : 8'h00;
      // Slow loop: move ends only after a settling delay
      o_move_done <= i_busy && (busy_cnt_reg == DONE_DLY[7:0]);
    end
  end
endmodule : sip_far_model
`default_nettype wire

// file: verif/sip_servo_ctrl_test.sv
// Self-checking bench for the position and protection block
`timescale 1ns/1ns
`default_nettype none
module sip_servo_ctrl_test;
  import sip_pkg::*;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [8:0] trq_cmd = 9'h000;
  logic batt_cmd = 1'b0;
  logic encr_cmd = 1'b0;
  logic [4:0] pin_cmd = 5'h00;
  wire logic [31:0] rdat;
  wire logic wait_rq, busy, en, batt_al, th_al, trq_r, irq, enc_rst, batt_f, done;
  wire logic [6:0] enc_cur;
  wire logic [15:0] accel, atten, tspd;
  wire logic [33:0] tpos;
  wire logic [5:0] poles;
  wire logic [8:0] trq;
  wire logic [4:0] pins;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  // Clock: 50 MHz
  always #10 i_mclk = ~i_mclk;
  // Short overload tick keeps the trip run near two thousand cycles
  sip_servo_ctrl #(.NUM_IN(5), .TICK_CYC(4)) sip_servo_ctrl_i (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_rq), .i_in_port(pins), .i_batt_fault(batt_f),
    .i_torque_pct(trq), .i_enc_resetting(enc_rst), .i_move_done(done), .o_servo_en(en),
    .o_batt_alarm(batt_al), .o_therm_alarm(th_al), .o_torque_reached(trq_r),
    .o_enc_current(enc_cur), .o_move_busy(busy), .o_target_pos(tpos), .o_target_speed(tspd),
    .o_accel(accel), .o_pole_pairs(poles), .o_gain_atten(atten), .o_irq(irq));
  sip_far_model sip_far_model_i (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_torque_cmd(trq_cmd), .i_batt_bad(batt_cmd),
    .i_enc_rst_cmd(encr_cmd), .i_pin_cmd(pin_cmd), .i_busy(busy), .o_torque_pct(trq),
    .o_batt_fault(batt_f), .o_enc_resetting(enc_rst), .o_in_port(pins), .o_move_done(done));
  // Verdict and end of run
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge i_mclk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (wait_rq !== 1'b0 && k < 50);
    q = rdat;
    if (k >= 50) bad_count++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask : rchk
  task automatic tick(input int c);
    repeat (c) @(posedge i_mclk);
  endtask : tick
  // Watchdog sized well above the longest scenario
  initial begin
    tick(30000);
    bad_count++;
    end_sim();
  end
  initial begin
    tick(20);
    i_sys_rst <= 1'b0;
    tick(2);
    chk("poles_out", 32'(poles), 32'h1);
    rchk("thdet", SIP_THDET_OFS, 32'h64);
    rchk("thtrq", SIP_THTRQ_OFS, 32'h12C);
    rchk("thtime", SIP_THTIME_OFS, 32'h1);
    rchk("atten", SIP_ATTEN_OFS, 32'h1);
    rchk("unmapped", 8'hFC, 32'h0);
    // Out-of-range writes are dropped, edge values kept
    wreg(SIP_THDET_OFS, 32'h9);
    rchk("thdet_lo", SIP_THDET_OFS, 32'h64);
    wreg(SIP_THTRQ_OFS, 32'h12D);
    rchk("thtrq_hi", SIP_THTRQ_OFS, 32'h12C);
    wreg(SIP_THTRQ_OFS, 32'h6E);
    wreg(SIP_POLES_OFS, 32'h25);
    rchk("poles_hi", SIP_POLES_OFS, 32'h1);
    wreg(SIP_POLES_OFS, 32'h24);
    wreg(SIP_ACCEL_OFS, 32'h7D1);
    rchk("accel_hi", SIP_ACCEL_OFS, 32'h0);
    wreg(SIP_ACCEL_OFS, 32'h7D0);
    wreg(SIP_ATTEN_OFS, 32'hBB8);
    wreg(SIP_ENCCUR_OFS, 32'h65);
    wreg(SIP_ENCCUR_OFS, 32'h32);
    tick(2);
    chk("poles_max", 32'(poles), 32'h24);
    chk("accel_out", 32'(accel), 32'h7D0);
    chk("atten_out", 32'(atten), 32'hBB8);
    chk("enc_idle", 32'(enc_cur), 32'h0);
    encr_cmd <= 1'b1;
    tick(4);
    chk("enc_cur", 32'(enc_cur), 32'h32);
    encr_cmd <= 1'b0;
    // Four entries, each with its own turns, pulses and speed
    for (int e = 0; e < 4; e++) begin
      wreg(8'h40 + 8'(16 * e), 32'h7FFF - 32'(e));
      wreg(8'h44 + 8'(16 * e), 32'h100 + 32'(e));
      wreg(8'h48 + 8'(16 * e), 32'h1770 - 32'(e));
      rchk("turns", 8'h40 + 8'(16 * e), 32'h7FFF - 32'(e));
      rchk("pulses", 8'h44 + 8'(16 * e), 32'h100 + 32'(e));
      rchk("speed", 8'h48 + 8'(16 * e), 32'h1770 - 32'(e));
    end
    wreg(8'h48, 32'h1771);
    rchk("speed_hi", 8'h48, 32'h1770);
    // Torque reached, kept under the detect point
    wreg(SIP_TRQRCH_OFS, 32'h50);
    trq_cmd <= 9'h04F;
    tick(4);
    chk("trq_below", 32'(trq_r), 32'h0);
    trq_cmd <= 9'h050;
    tick(4);
    chk("trq_at", 32'(trq_r), 32'h1);
    // Battery fault with the check off, then on
    batt_cmd <= 1'b1;
    tick(6);
    chk("batt_off", 32'(batt_al), 32'h0);
    rchk("istat_a", SIP_ISTAT_OFS, 32'h4);
    wreg(SIP_CTRL_OFS, 32'h1);
    tick(4);
    chk("batt_on", 32'(batt_al), 32'h1);
    wreg(SIP_IMASK_OFS, 32'h1);
    tick(2);
    chk("irq_batt", 32'(irq), 32'h1);
    wreg(SIP_ISTAT_OFS, 32'h5);
    tick(2);
    chk("irq_clr", 32'(irq), 32'h0);
    batt_cmd <= 1'b0;
    // Enable sources: forced, fixed port 0, coded port 1
    wreg(SIP_CTRL_OFS, 32'h2);
    tick(3);
    chk("en_force", 32'(en), 32'h1);
    wreg(SIP_CTRL_OFS, 32'h0);
    tick(3);
    chk("en_off", 32'(en), 32'h0);
    pin_cmd <= 5'h01;
    tick(5);
    chk("en_port0", 32'(en), 32'h1);
    pin_cmd <= 5'h02;
    tick(5);
    chk("en_nofn", 32'(en), 32'h0);
    wreg(SIP_INFUNC_OFS, 32'h1);
    tick(3);
    chk("en_port1", 32'(en), 32'h1);
    pin_cmd <= 5'h00;
    // Move to entry 1 (-2 turns, -1000 pulses); ports 1..3 carry codes 16, 17, 18
    wreg(8'h50, 32'hFFFE);
    wreg(8'h54, 32'hFC18);
    wreg(SIP_INFUNC_OFS, 32'hA98);
    pin_cmd <= 5'h02;
    tick(1);
    pin_cmd <= 5'h0A;
    tick(5);
    chk("busy_on", 32'(busy), 32'h1);
    chk("tpos", 32'(tpos[33:2]), 32'hFFFE_FC18);
    chk("tspd", 32'(tspd), 32'h176F);
    chk("atten_move", 32'(atten), 32'h1);
    // Selection moves to entry 2 while running; start stays high
    pin_cmd <= 5'h0C;
    tick(6);
    chk("busy_off", 32'(busy), 32'h0);
    chk("tpos_hold", 32'(tpos[33:2]), 32'hFFFE_FC18);
    rchk("istat_done", SIP_ISTAT_OFS, 32'h8);
    pin_cmd <= 5'h00;
    // Overload: limit (110^2-100^2)*1000, 4400 per tick at 120 percent
    wreg(SIP_CTRL_OFS, 32'h2);
    wreg(SIP_IMASK_OFS, 32'h2);
    trq_cmd <= 9'h078;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (th_al !== 1'b1 && n < 3000);
    chk("trip_time", 32'(n >= 1905 && n <= 1925), 32'h1);
    tick(3);
    chk("trip_en", 32'(en), 32'h0);
    chk("irq_th", 32'(irq), 32'h1);
    wreg(SIP_CTRL_OFS, 32'h6);
    tick(3);
    chk("trip_hold", 32'(th_al), 32'h1);
    trq_cmd <= 9'h000;
    tick(1200);
    wreg(SIP_CTRL_OFS, 32'h6);
    tick(3);
    chk("trip_clr", 32'(th_al), 32'h0);
    chk("en_back", 32'(en), 32'h1);
    wreg(SIP_ISTAT_OFS, 32'hF);
    tick(2);
    chk("irq_end", 32'(irq), 32'h0);
    end_sim();
  end
endmodule : sip_servo_ctrl_test
`default_nettype wire
